// ==== include/ittsr_pkg.sv ====
package ittsr_pkg;
    // link widths
    localparam int DW    = 8;
    localparam int SEL_W = 5;
    localparam int CH_N  = 9;
    // register map, byte addresses on the link
    localparam logic [7:0] A_KEY_HI  = 8'h00;
    localparam logic [7:0] A_KEY_LO  = 8'h01;
    localparam logic [7:0] A_TRY_HI  = 8'h02;
    localparam logic [7:0] A_TRY_LO  = 8'h03;
    localparam logic [7:0] A_SEL     = 8'h04;
    localparam logic [7:0] A_VAL     = 8'h05;
    localparam logic [7:0] A_STAT    = 8'h06;
    localparam logic [7:0] A_TLM     = 8'h08;
    localparam logic [7:0] A_TLM_END = 8'h10;
    // last legal selector value
    localparam logic [4:0] SEL_LAST  = 5'h11;
    // protection classes
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_CFG  = 2'h1;
    // release methods
    localparam logic [1:0] UNL_PW    = 2'h0;
    localparam logic [1:0] UNL_PIN   = 2'h1;
    localparam logic [1:0] UNL_BOTH  = 2'h2;
    // key store reset value, arbitrary nonzero
    localparam logic [15:0] KEY_RST  = 16'h5A3C;
    localparam logic [15:0] KEY_NULL = 16'h0000;
    localparam logic [2:0] FAIL_LIM  = 3'h4;
    // status bit positions
    localparam int ST_RD   = 0;
    localparam int ST_WR   = 1;
    localparam int ST_PW   = 2;
    localparam int ST_LOCK = 3;
    // scaling: iin in 1/128 A, iout in 1/8 A, volts in mV
    localparam int IIN_FIX_SH  = 2;
    localparam int DUTY_SH     = 7;
    localparam int IIN_RPT_SH  = 4;
    localparam int IOUT_RPT_SH = 2;
    localparam int LL_SH       = 3;
    localparam int VOUT_RPT_SH = 6;
    localparam int VIN_RPT_SH  = 7;
    localparam int TEMP_RPT_SH = 0;
    // voltage code to mV, per code mode
    localparam int VC_BASE0  = 250;
    localparam int VC_STEP0  = 5;
    localparam int VC_BASE1  = 500;
    localparam int VC_STEP1  = 10;
    localparam int VOFF_STEP0 = 5;
    localparam int VOFF_STEP1 = 10;
    // capture reset values
    localparam logic [7:0] MIN_RST = 8'hFF;
    localparam logic [7:0] MAX_RST = 8'h00;
    // host wait for address trim, least time rounds up
    localparam int CLK_NS   = 25;
    localparam int TRIM_NS  = 100000;
    localparam int TRIM_CYC = (TRIM_NS + CLK_NS - 1) / CLK_NS;

    // host sequencer states
    typedef enum logic [1:0] {H_IDLE = 2'b01, H_WAIT = 2'b10} ittsr_hst_t;

    // shift and clamp to an unsigned byte
    function automatic logic [7:0] ittsr_sat8(input logic signed [23:0] v, input int sh);
        logic signed [23:0] s;
        s = v >>> sh;
        if (s < 0) begin
            return 8'h00;
        end
        if (s > 24'sh0000FF) begin
            return 8'hFF;
        end
        return s[7:0];
    endfunction : ittsr_sat8

    // release state for one method
    function automatic logic ittsr_unl(input logic [1:0] m, input logic pw, input logic pin);
        case (m)
            UNL_PW:   return pw;
            UNL_PIN:  return pin;
            UNL_BOTH: return pw & pin;
            default:  return 1'b0;
        endcase
    endfunction : ittsr_unl

    // access allowed under a protection class
    function automatic logic ittsr_gate(input logic [1:0] p, input logic open, input logic cfg);
        return (p == PROT_NONE) | ((p == PROT_CFG) & ~cfg) | open;
    endfunction : ittsr_gate
endpackage : ittsr_pkg

// ==== include/ittsr_link_if.sv ====
`timescale 1ns/10ps
interface ittsr_link_if;
    logic       req_valid;   // request strobe
    logic       req_write;   // 1 write, 0 read
    logic [7:0] req_addr;    // register address
    logic [7:0] req_wdata;   // write byte
    logic       rsp_valid;   // answer strobe
    logic       rsp_refused; // request not carried out
    logic [7:0] rsp_rdata;   // read byte
    logic       prot_o;      // host protect level
    logic       prot_oe;     // host drives protect pin
    logic       prot_pin;    // resolved pin, low when undriven
    // pin level from the host enable
    assign prot_pin = prot_oe & prot_o;
    modport dev  (input req_valid, req_write, req_addr, req_wdata, prot_pin,
                  output rsp_valid, rsp_refused, rsp_rdata);
    modport host (output req_valid, req_write, req_addr, req_wdata, prot_o, prot_oe,
                  input rsp_valid, rsp_refused, rsp_rdata);
endinterface : ittsr_link_if

// ==== rtl/ittsr_extreme_track.sv ====
`timescale 1ns/10ps
module ittsr_extreme_track #(
    parameter int CH = 9,
    parameter int W  = 8
) (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_rst_n,
    input  wire logic [CH-1:0][W-1:0]       i_sample,   // one byte per channel
    input  wire logic                       i_clr,      // a capture was read
    input  wire logic [ittsr_pkg::SEL_W-1:0] i_clr_slot, // which capture
    output logic      [2*CH-1:0][W-1:0]     o_ext       // even min, odd max
);
    logic [2*CH-1:0][W-1:0] ext_r; // capture store

    // track extremes, a read restarts from the present sample
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < 2*CH; s++) begin
                ext_r[s] <= (s % 2 == 1) ? ittsr_pkg::MAX_RST : ittsr_pkg::MIN_RST;
            end
        end else begin
            for (int s = 0; s < 2*CH; s++) begin
                if (i_clr && (i_clr_slot == ittsr_pkg::SEL_W'(s))) begin
                    ext_r[s] <= i_sample[s/2];
                end else if ((s % 2 == 1) ? (i_sample[s/2] > ext_r[s]) : (i_sample[s/2] < ext_r[s])) begin
                    ext_r[s] <= i_sample[s/2];
                end
            end
        end
    end

    assign o_ext = ext_r;
endmodule : ittsr_extreme_track

// ==== rtl/ittsr_dev_end.sv ====
// Function
// - all five measurements readable in real time
// - output voltage from code and load line
// - fixed input trim in 1/32 A
// - phase input trim times active phases
// - signed output trim per phase, 1/8 A
// - voltage trim step follows code mode
// - signed temperature trim in one degree
// - duty adjust scales input current
// - read and write protection classes separate
// - release by password, pin, both, never
// - 16-bit key, zero never matches
// - host writes attempt high then low
// - four misses lock all but status reads
// - new key high byte relocks device
// - latch strap at enable, then protect
// - host drives protect, device follows
// - host waits trim time before driving
// - selector then value reads captures
// - captures since read, restarted from the present sample on read
// - selector five bits, value eight bits
// - selector 0..17 pairs min then max
// - strap offset added to base address
`timescale 1ns/10ps
module ittsr_dev_end (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    ittsr_link_if.dev              lnk,
    input  wire logic              i_enable,       // pin, synchronised
    input  wire logic [3:0]        i_addr_strap,   // converted strap resistor
    input  wire logic [6:0]        i_base_addr,    // programmed bus address
    input  wire logic              i_addr_off_en,  // strap offset enable
    input  wire logic [1:0]        i_rd_prot,      // read protection class
    input  wire logic [1:0]        i_wr_prot,      // write protection class
    input  wire logic [1:0]        i_rd_method,    // read release method
    input  wire logic [1:0]        i_wr_method,    // write release method
    input  wire logic [1:0][15:0]  i_iin_raw,      // 1/128 A
    input  wire logic [1:0][15:0]  i_iout_raw,     // signed, 1/8 A
    input  wire logic [1:0][7:0]   i_vcode,        // commanded voltage code
    input  wire logic [1:0][3:0]   i_phases,       // active phases
    input  wire logic [1:0][7:0]   i_temp_raw,     // signed degrees
    input  wire logic [15:0]       i_vin_raw,      // mV
    input  wire logic [7:0]        i_loadline,     // mV per A
    input  wire logic              i_vc_mode,      // voltage code mode
    input  wire logic [7:0]        i_iin_fix,      // 1/32 A
    input  wire logic [7:0]        i_iin_phase,    // 1/128 A
    input  wire logic signed [4:0] i_iout_trim,    // 1/8 A
    input  wire logic signed [3:0] i_vout_trim,    // mode step
    input  wire logic signed [5:0] i_temp_trim,    // degrees
    input  wire logic signed [7:0] i_duty_adj,     // 1/128 of input current
    output logic [6:0]             o_bus_addr,     // effective bus address
    output logic                   o_rd_open,      // reads released
    output logic                   o_wr_open,      // writes released
    output logic                   o_lockup        // too many misses
);
    localparam int CH = ittsr_pkg::CH_N;

    // synchronisers and edge detect
    logic prot_s1_r, prot_s2_r;       // protect pin
    logic en_s1_r, en_s2_r, en_d_r;   // enable pin
    // state
    logic [15:0] key_r;               // key store
    logic [15:0] try_r;               // attempt register
    logic [4:0]  sel_r;               // capture selector
    logic        pw_ok_r;             // password matched
    logic [2:0]  fails_r;             // missed attempts
    logic        lock_r;              // locked up
    logic        rd_val;              // capture slot read, reloads it
    logic        rd_open_r, wr_open_r;
    logic [6:0]  addr_r;
    logic        rsp_v_r, rsp_ref_r;
    logic [7:0]  rsp_d_r;
    // telemetry
    logic signed [23:0] iin_w  [2];
    logic signed [23:0] iout_w [2];
    logic signed [23:0] vout_w [2];
    logic signed [23:0] temp_w [2];
    logic [CH-1:0][7:0]     tlm;      // reported bytes
    logic [2*CH-1:0][7:0]   ext;      // capture bytes

    // pins cross into the core clock
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {prot_s1_r, prot_s2_r, en_s1_r, en_s2_r, en_d_r} <= 5'h00;
        end else begin
            prot_s1_r <= lnk.prot_pin;
            prot_s2_r <= prot_s1_r;
            en_s1_r   <= i_enable;
            en_s2_r   <= en_s1_r;
            en_d_r    <= en_s2_r;
        end
    end

    // address latched at each enable rise, pin is protect afterwards
    wire logic en_rise = en_s2_r & ~en_d_r;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_r <= 7'h00;
        end else if (en_rise) begin
            addr_r <= i_base_addr + (i_addr_off_en ? {3'h0, i_addr_strap} : 7'h00);
        end
    end

    // telemetry with trims applied per loop
    // signed so the voltage sum stays signed
    wire logic signed [23:0] vc_base  = 24'(i_vc_mode ? ittsr_pkg::VC_BASE1 : ittsr_pkg::VC_BASE0);
    wire logic signed [23:0] vc_step  = 24'(i_vc_mode ? ittsr_pkg::VC_STEP1 : ittsr_pkg::VC_STEP0);
    wire logic signed [23:0] voff_stp = 24'(i_vc_mode ? ittsr_pkg::VOFF_STEP1 : ittsr_pkg::VOFF_STEP0);
    always_comb begin
        for (int l = 0; l < 2; l++) begin
            iin_w[l] = $signed({8'h00, i_iin_raw[l]})
                     + (($signed({8'h00, i_iin_raw[l]}) * i_duty_adj) >>> ittsr_pkg::DUTY_SH)
                     + ($signed({16'h0000, i_iin_fix}) <<< ittsr_pkg::IIN_FIX_SH)
                     + $signed({16'h0000, i_iin_phase}) * $signed({20'h00000, i_phases[l]});
            iout_w[l] = $signed(i_iout_raw[l]) + i_iout_trim * $signed({20'h00000, i_phases[l]});
            vout_w[l] = 24'(vc_base) + $signed({16'h0000, i_vcode[l]}) * 24'(vc_step)
                      - (($signed(i_iout_raw[l]) * $signed({16'h0000, i_loadline})) >>> ittsr_pkg::LL_SH)
                      + i_vout_trim * 24'(voff_stp);
            temp_w[l] = $signed(i_temp_raw[l]) + i_temp_trim;
        end
        // channel order follows selector pairs
        tlm[0] = ittsr_pkg::ittsr_sat8(iout_w[0], ittsr_pkg::IOUT_RPT_SH);
        tlm[1] = ittsr_pkg::ittsr_sat8(iout_w[1], ittsr_pkg::IOUT_RPT_SH);
        tlm[2] = ittsr_pkg::ittsr_sat8(iin_w[0], ittsr_pkg::IIN_RPT_SH);
        tlm[3] = ittsr_pkg::ittsr_sat8(iin_w[1], ittsr_pkg::IIN_RPT_SH);
        tlm[4] = ittsr_pkg::ittsr_sat8(vout_w[0], ittsr_pkg::VOUT_RPT_SH);
        tlm[5] = ittsr_pkg::ittsr_sat8(vout_w[1], ittsr_pkg::VOUT_RPT_SH);
        tlm[6] = ittsr_pkg::ittsr_sat8($signed({8'h00, i_vin_raw}), ittsr_pkg::VIN_RPT_SH);
        tlm[7] = ittsr_pkg::ittsr_sat8(temp_w[0], ittsr_pkg::TEMP_RPT_SH);
        tlm[8] = ittsr_pkg::ittsr_sat8(temp_w[1], ittsr_pkg::TEMP_RPT_SH);
    end

    // min and max captures
    wire logic sel_ok = (sel_r <= ittsr_pkg::SEL_LAST);
    ittsr_extreme_track #(.CH(CH), .W(8)) u_track (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_sample   (tlm),
        .i_clr      (rd_val),
        .i_clr_slot (sel_r),
        .o_ext      (ext)
    );

    // address classes
    wire logic [7:0] a      = lnk.req_addr;
    wire logic is_tlm       = (a >= ittsr_pkg::A_TLM) && (a <= ittsr_pkg::A_TLM_END);
    wire logic [3:0] tlm_ix = 4'(a - ittsr_pkg::A_TLM);
    wire logic is_cfg       = (a == ittsr_pkg::A_KEY_HI) | (a == ittsr_pkg::A_KEY_LO) | (a == ittsr_pkg::A_SEL);
    wire logic is_free      = (a == ittsr_pkg::A_TRY_HI) | (a == ittsr_pkg::A_TRY_LO) | (a == ittsr_pkg::A_STAT);
    wire logic rd_map       = is_cfg | is_free | is_tlm | (a == ittsr_pkg::A_VAL);
    wire logic wr_map       = is_cfg | (a == ittsr_pkg::A_TRY_HI) | (a == ittsr_pkg::A_TRY_LO);

    // access checks; lockup refuses all but status
    wire logic rd_gate = is_free | ittsr_pkg::ittsr_gate(i_rd_prot, rd_open_r, is_cfg);
    wire logic wr_gate = is_free | ittsr_pkg::ittsr_gate(i_wr_prot, wr_open_r, is_cfg);
    wire logic rd_ok   = rd_map & (lock_r ? (a == ittsr_pkg::A_STAT) : rd_gate);
    wire logic wr_ok   = wr_map & ~lock_r & wr_gate;
    wire logic do_rd   = lnk.req_valid & ~lnk.req_write & rd_ok;
    wire logic do_wr   = lnk.req_valid & lnk.req_write & wr_ok;
    assign rd_val      = do_rd & (a == ittsr_pkg::A_VAL) & sel_ok;
    wire logic [7:0] d = lnk.req_wdata;

    // password attempt on the low byte
    wire logic try_lo  = do_wr & (a == ittsr_pkg::A_TRY_LO);
    wire logic match   = ({try_r[15:8], d} == key_r) & (key_r != ittsr_pkg::KEY_NULL);
    wire logic [2:0] fails_inc = fails_r + 3'h1;
    wire logic key_wr  = do_wr & ((a == ittsr_pkg::A_KEY_HI) | (a == ittsr_pkg::A_KEY_LO));

    // key, attempt and selector writes
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_r <= ittsr_pkg::KEY_RST;
            try_r <= 16'h0000;
            sel_r <= 5'h00;
        end else if (do_wr) begin
            if (a == ittsr_pkg::A_KEY_HI) key_r[15:8] <= d;
            if (a == ittsr_pkg::A_KEY_LO) key_r[7:0]  <= d;
            if (a == ittsr_pkg::A_TRY_HI) try_r[15:8] <= d;
            if (a == ittsr_pkg::A_TRY_LO) try_r[7:0]  <= d;
            if (a == ittsr_pkg::A_SEL)    sel_r       <= d[4:0];
        end
    end

    // match, miss count and lockup
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pw_ok_r <= 1'b0;
            fails_r <= 3'h0;
            lock_r  <= 1'b0;
        end else if (key_wr) begin
            pw_ok_r <= 1'b0;
        end else if (try_lo) begin
            pw_ok_r <= match;
            if (match) begin
                fails_r <= 3'h0;
            end else begin
                fails_r <= fails_inc;
                if (fails_inc == ittsr_pkg::FAIL_LIM) lock_r <= 1'b1;
            end
        end
    end

    // release state follows pin and password
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_open_r <= 1'b0;
            wr_open_r <= 1'b0;
        end else begin
            rd_open_r <= ittsr_pkg::ittsr_unl(i_rd_method, pw_ok_r, prot_s2_r);
            wr_open_r <= ittsr_pkg::ittsr_unl(i_wr_method, pw_ok_r, prot_s2_r);
        end
    end

    // read data selection
    logic [7:0] stat;
    always_comb begin
        stat                     = 8'h00;
        stat[ittsr_pkg::ST_RD]   = rd_open_r;
        stat[ittsr_pkg::ST_WR]   = wr_open_r;
        stat[ittsr_pkg::ST_PW]   = pw_ok_r;
        stat[ittsr_pkg::ST_LOCK] = lock_r;
    end
    wire logic [7:0] val_d = sel_ok ? ext[sel_r] : 8'h00;
    wire logic [7:0] rd_mux =
        (a == ittsr_pkg::A_KEY_HI) ? key_r[15:8] :
        (a == ittsr_pkg::A_KEY_LO) ? key_r[7:0]  :
        (a == ittsr_pkg::A_TRY_HI) ? try_r[15:8] :
        (a == ittsr_pkg::A_TRY_LO) ? try_r[7:0]  :
        (a == ittsr_pkg::A_SEL)    ? {3'h0, sel_r} :
        (a == ittsr_pkg::A_VAL)    ? val_d :
        (a == ittsr_pkg::A_STAT)   ? stat  :
        (is_tlm && (tlm_ix < 4'(CH))) ? tlm[tlm_ix] : 8'h00;

    // one answer per request, next cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_v_r   <= 1'b0;
            rsp_ref_r <= 1'b0;
            rsp_d_r   <= 8'h00;
        end else begin
            rsp_v_r   <= lnk.req_valid;
            rsp_ref_r <= lnk.req_valid & ~(do_rd | do_wr);
            rsp_d_r   <= do_rd ? rd_mux : 8'h00;
        end
    end

    assign lnk.rsp_valid   = rsp_v_r;
    assign lnk.rsp_refused = rsp_ref_r;
    assign lnk.rsp_rdata   = rsp_d_r;
    assign o_bus_addr      = addr_r;
    assign o_rd_open       = rd_open_r;
    assign o_wr_open       = wr_open_r;
    assign o_lockup        = lock_r;
endmodule : ittsr_dev_end

// ==== rtl/ittsr_host_end.sv ====
`timescale 1ns/10ps
module ittsr_host_end #(
    parameter int TRIM_CYC = ittsr_pkg::TRIM_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    ittsr_link_if.host       lnk,
    input  wire logic        i_cmd_valid,   // user request
    input  wire logic        i_cmd_write,   // 1 write
    input  wire logic [7:0]  i_cmd_addr,    // register address
    input  wire logic [7:0]  i_cmd_wdata,   // write byte
    input  wire logic        i_unlock_go,   // send a key as two attempt bytes
    input  wire logic [15:0] i_unlock_key,  // key to try
    input  wire logic        i_protect_lvl, // wanted protect level
    output logic             o_cmd_ready,   // idle, request or unlock taken
    output logic             o_rsp_valid,   // answer pulse
    output logic             o_rsp_refused, // device refused
    output logic [7:0]       o_rsp_data,    // read byte
    output logic             o_prot_armed   // trim wait over
);
    ittsr_pkg::ittsr_hst_t st_r, st_nxt;   // sequencer
    logic        rv_r, rw_r;               // request strobe and kind
    logic [7:0]  ra_r, rd_r;               // request address and data
    logic        lo_pend_r;                // attempt low byte owed
    logic [7:0]  key_lo_r;                 // held low byte
    logic        rdy_r, ov_r, oref_r;
    logic [7:0]  odat_r;
    logic [15:0] trim_cnt_r;               // trim wait counter
    logic        armed_r, po_r, poe_r;

    // next state
    wire logic start = i_unlock_go | i_cmd_valid;
    wire logic done  = lnk.rsp_valid;
    always_comb begin
        case (st_r)
            ittsr_pkg::H_IDLE: st_nxt = start ? ittsr_pkg::H_WAIT : ittsr_pkg::H_IDLE;
            ittsr_pkg::H_WAIT: st_nxt = (done && !lo_pend_r) ? ittsr_pkg::H_IDLE : ittsr_pkg::H_WAIT;
            default:           st_nxt = ittsr_pkg::H_IDLE;
        endcase
    end

    // issue requests; unlock sends high byte then low byte
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ittsr_pkg::H_IDLE;
            {rv_r, rw_r, lo_pend_r} <= 3'h0;
            {ra_r, rd_r, key_lo_r}  <= 24'h000000;
        end else begin
            st_r <= st_nxt;
            rv_r <= 1'b0;
            if (st_r == ittsr_pkg::H_IDLE && i_unlock_go) begin
                {rv_r, rw_r, ra_r, rd_r} <= {2'h3, ittsr_pkg::A_TRY_HI, i_unlock_key[15:8]};
                key_lo_r  <= i_unlock_key[7:0];
                lo_pend_r <= 1'b1;
            end else if (st_r == ittsr_pkg::H_IDLE && i_cmd_valid) begin
                {rv_r, rw_r, ra_r, rd_r} <= {1'b1, i_cmd_write, i_cmd_addr, i_cmd_wdata};
            end else if (st_r == ittsr_pkg::H_WAIT && done && lo_pend_r) begin
                {rv_r, rw_r, ra_r, rd_r} <= {2'h3, ittsr_pkg::A_TRY_LO, key_lo_r};
                lo_pend_r <= 1'b0;
            end
        end
    end

    // answers to the user
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {rdy_r, ov_r, oref_r} <= 3'h0;
            odat_r <= 8'h00;
        end else begin
            rdy_r  <= (st_nxt == ittsr_pkg::H_IDLE);
            ov_r   <= done;
            oref_r <= done & lnk.rsp_refused;
            odat_r <= done ? lnk.rsp_rdata : odat_r;
        end
    end

    // protect pin held off until strap trim is over
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_cnt_r <= 16'h0000;
            {armed_r, po_r, poe_r} <= 3'h0;
        end else begin
            if (!armed_r) trim_cnt_r <= trim_cnt_r + 16'h0001;
            if (trim_cnt_r == 16'(TRIM_CYC - 1)) armed_r <= 1'b1;
            poe_r <= armed_r;
            po_r  <= armed_r & i_protect_lvl;
        end
    end

    assign lnk.req_valid = rv_r;
    assign lnk.req_write = rw_r;
    assign lnk.req_addr  = ra_r;
    assign lnk.req_wdata = rd_r;
    assign lnk.prot_o    = po_r;
    assign lnk.prot_oe   = poe_r;
    assign o_cmd_ready   = rdy_r;
    assign o_rsp_valid   = ov_r;
    assign o_rsp_refused = oref_r;
    assign o_rsp_data    = odat_r;
    assign o_prot_armed  = armed_r;
endmodule : ittsr_host_end

// ==== dv/ittsr_link_props.sv ====
`timescale 1ns/10ps
module ittsr_link_props (
    input wire logic       i_core_clk, i_rst_n, req_valid, req_write, rsp_valid, rsp_refused,
    input wire logic [7:0] req_addr, req_wdata, rsp_rdata
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic [4:0] sel_r; // last selector written
    // follow selector writes
    always_ff @(posedge i_core_clk) begin
        if (req_valid & req_write & (req_addr == ittsr_pkg::A_SEL)) sel_r <= req_wdata[4:0];
    end
    a_rsp_next: assert property (req_valid |=> rsp_valid) else $error("no answer");
    a_rsp_cause: assert property (rsp_valid |-> $past(req_valid)) else $error("stray answer");
    a_refuse_zero: assert property (rsp_refused |-> rsp_valid && rsp_rdata == 8'h00) else $error("bad refusal");
    a_req_gap: assert property (req_valid |=> !req_valid) else $error("early request");
    a_write_zero: assert property (rsp_valid && $past(req_write) |-> rsp_rdata == 8'h00) else $error("write data");
    a_sel_zero: assert property (req_valid && !req_write && req_addr == ittsr_pkg::A_VAL && sel_r > ittsr_pkg::SEL_LAST
        |=> rsp_rdata == 8'h00) else $error("high selector data");
    a_unmapped_ref: assert property (req_valid && (req_addr == 8'h07 || req_addr > ittsr_pkg::A_TLM_END) |=> rsp_refused)
        else $error("unmapped taken");
    a_ro_write: assert property (req_valid && req_write && req_addr == ittsr_pkg::A_VAL |=> rsp_refused)
        else $error("value write taken");
endmodule : ittsr_link_props

// ==== dv/i2c_telemetry_security_regs_tb.sv ====
`timescale 1ns/10ps
module i2c_telemetry_security_regs_tb;
    logic i_core_clk = 0, i_rst_n = 0, i_enable = 0, i_addr_off_en = 1, i_vc_mode, i_protect_lvl = 0, o_rd_open;
    logic i_cmd_valid = 0, i_cmd_write = 0, i_unlock_go = 0, o_lockup, o_cmd_ready, o_rsp_valid, o_rsp_refused;
    logic o_wr_open, o_prot_armed;
    logic [7:0] i_cmd_addr = 0, i_cmd_wdata = 0, i_loadline, i_iin_fix, i_iin_phase, o_rsp_data;
    logic [15:0] i_unlock_key = 0, i_vin_raw;
    logic [1:0] i_rd_prot = 0, i_wr_prot = 0, i_rd_method = 0, i_wr_method = 0;
    logic [1:0][15:0] i_iin_raw, i_iout_raw;
    logic [1:0][7:0] i_vcode, i_temp_raw = 16'h1E28; // 30 and 40 degrees
    logic [1:0][3:0] i_phases;
    logic [3:0] i_addr_strap = 4'hF;
    logic [6:0] i_base_addr = 7'h28, o_bus_addr;
    logic signed [4:0] i_iout_trim;
    logic signed [3:0] i_vout_trim;
    logic signed [5:0] i_temp_trim = 6'h3D; // minus three degrees
    logic signed [7:0] i_duty_adj;
    logic [8:0] exp_q[$]; // expected refused flag and byte
    int checks = 0, n_mismatch = 0;
    ittsr_link_if lnk ();
    ittsr_dev_end i_ittsr_dev_end (.*);
    ittsr_host_end #(.TRIM_CYC(8)) i_ittsr_host_end (.*);
    ittsr_link_props i_ittsr_link_props (.i_core_clk, .i_rst_n, .req_valid(lnk.req_valid), .req_write(lnk.req_write),
        .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata), .rsp_valid(lnk.rsp_valid),
        .rsp_refused(lnk.rsp_refused), .rsp_rdata(lnk.rsp_rdata));
    always #12.5 i_core_clk = ~i_core_clk;
    // seeded random measurements and trims each cycle, all but temperature and its trim
    initial begin
        void'($urandom(1629));
        forever begin
            {i_iin_raw, i_iout_raw, i_vcode, i_phases, i_vin_raw, i_loadline, i_iin_fix, i_iin_phase}
                <= {$urandom, $urandom, $urandom, $urandom};
            {i_iout_trim, i_vout_trim, i_duty_adj, i_vc_mode} <= 18'($urandom);
            @(posedge i_core_clk);
        end
    end
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    // one command or key try, then a bounded wait for idle
    task automatic cmd(input logic u, w, input logic [7:0] a, d, input logic [8:0] e);
        exp_q.push_back(e);
        if (u) exp_q.push_back(e);
        {i_unlock_go, i_cmd_valid, i_cmd_write, i_cmd_addr, i_cmd_wdata, i_unlock_key} <= {u, ~u, w, a, d, a, d};
        @(posedge i_core_clk);
        {i_unlock_go, i_cmd_valid} <= 2'b00;
        @(posedge i_core_clk);
        for (int i = 0; i < 40 && o_cmd_ready !== 1'b1; i++) @(posedge i_core_clk);
        if (o_cmd_ready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : cmd
    // oldest expectation against each answer
    always @(posedge i_core_clk) begin
        if (o_rsp_valid === 1'b1) begin
            chk(exp_q.size() > 0 && {o_rsp_refused, o_rsp_data} === exp_q[0], "answer");
            if (exp_q.size() > 0) exp_q.delete(0);
        end
    end
    initial begin
        logic [15:0] k;
        repeat (5) @(posedge i_core_clk);
        {i_rst_n, i_enable} <= 2'b11;
        repeat (8) @(posedge i_core_clk);
        chk(o_bus_addr === 7'h37, "address");
        cmd(1, 1, 8'h5A, 8'h3C, 9'h000);
        chk(o_rd_open === 1'b1 && o_wr_open === 1'b1, "password release");
        cmd(0, 0, 8'h07, 8'h00, 9'h100);
        cmd(0, 1, ittsr_pkg::A_VAL, 8'h00, 9'h100);
        cmd(0, 0, 8'h0F, 8'h00, 9'h025);
        for (int s = 14; s < 20; s++) begin
            cmd(0, 1, ittsr_pkg::A_SEL, 8'(s), 9'h000);
            cmd(0, 0, ittsr_pkg::A_VAL, 8'h00, s > 17 ? 9'h000 : s < 16 ? 9'h025 : 9'h01B);
        end
        $display("test captures done");
        chk(o_prot_armed === 1'b1, "trim wait");
        {i_rd_method, i_protect_lvl} <= {ittsr_pkg::UNL_PIN, 1'b1};
        repeat (6) @(posedge i_core_clk);
        chk(o_rd_open === 1'b1, "pin release");
        i_protect_lvl <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        chk(o_rd_open === 1'b0, "pin lock");
        i_rd_method <= ittsr_pkg::UNL_PW;
        $display("test pin done");
        cmd(0, 1, ittsr_pkg::A_KEY_HI, 8'h00, 9'h000);
        chk(o_rd_open === 1'b0, "key write relock");
        cmd(0, 1, ittsr_pkg::A_KEY_LO, 8'h00, 9'h000);
        for (int i = 0; i < 4; i++) begin
            k = i == 0 ? 16'h0000 : 16'h5A3C ^ 16'(i);
            cmd(1, 1, k[15:8], k[7:0], 9'h000);
            chk(o_lockup === (i == 3) && o_rd_open === 1'b0, "zero key or lockup");
        end
        cmd(0, 0, ittsr_pkg::A_SEL, 8'h00, 9'h100);
        $display("test lockup done");
        @(posedge i_core_clk);
        chk(exp_q.size() == 0, "answers missing");
        @(posedge i_core_clk);
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
endmodule : i2c_telemetry_security_regs_tb
